// ===== core/srt_pkg.sv
package srt_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned SRT_CNT_W = 16;
    localparam int unsigned SRT_DAT_W = 32;
    localparam int unsigned SRT_ADR_W = 8;
    localparam int unsigned SRT_PSC_W = 8;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] SRT_OFS_CTRL = 8'h00;
    localparam logic [7:0] SRT_OFS_COUNT = 8'h04;
    localparam logic [7:0] SRT_OFS_PERIOD = 8'h08;
    localparam logic [7:0] SRT_OFS_STATUS = 8'h0c;
    localparam logic [7:0] SRT_OFS_MASK = 8'h10;
    localparam logic [7:0] SRT_OFS_CFG = 8'h14;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned SRT_BIT_RUN = 15;
    localparam int unsigned SRT_BIT_IDLE_HALT = 13;
    localparam int unsigned SRT_BIT_GATE = 6;
    localparam int unsigned SRT_BIT_PSC_HI = 5;
    localparam int unsigned SRT_BIT_PSC_LO = 4;
    localparam int unsigned SRT_BIT_SYNC = 2;
    localparam int unsigned SRT_BIT_SRC = 1;
    localparam int unsigned SRT_BIT_LPOSC = 0;
    localparam int unsigned SRT_BIT_EVT = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] SRT_CTRL_RST = 16'h0000;
    localparam logic [15:0] SRT_COUNT_RST = 16'h0000;
    localparam logic [15:0] SRT_PERIOD_RST = 16'hffff;

    // ----------------------------------------------------------------
    // prescale codes and terminal counts
    // ----------------------------------------------------------------
    localparam logic [1:0] SRT_PSC_DIV1 = 2'h0;
    localparam logic [1:0] SRT_PSC_DIV8 = 2'h1;
    localparam logic [1:0] SRT_PSC_DIV64 = 2'h2;
    localparam logic [1:0] SRT_PSC_DIV256 = 2'h3;
    localparam logic [7:0] SRT_LAST_DIV1 = 8'h00;
    localparam logic [7:0] SRT_LAST_DIV8 = 8'h07;
    localparam logic [7:0] SRT_LAST_DIV64 = 8'h3f;
    localparam logic [7:0] SRT_LAST_DIV256 = 8'hff;

    // ----------------------------------------------------------------
    // operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SRT_MODE_TIMER,
        SRT_MODE_GATED,
        SRT_MODE_SYNC_CNT,
        SRT_MODE_ASYNC_CNT
    } srt_mode_e;

endpackage

// ===== core/srt_psc_if.sv
// ----------------------------------------------------------------
// link between timer core and its prescaler
// ----------------------------------------------------------------
interface srt_psc_if;
    logic tick_in;
    logic [1:0] ratio;
    logic clear;
    logic tick_out;

    modport ctl
    (
        output tick_in,
        output ratio,
        output clear,
        input tick_out
    );

    modport psc
    (
        input tick_in,
        input ratio,
        input clear,
        output tick_out
    );
endinterface

// ===== core/srt_prescaler.sv
module srt_prescaler
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // tick link
    srt_psc_if.psc psc
);
    import srt_pkg::*;

    typedef struct packed {
        logic [SRT_PSC_W-1:0] div_cnt;
        logic tick;
    } srt_psc_s;

    srt_psc_s st_ff;
    srt_psc_s nxt_st;
    logic [SRT_PSC_W-1:0] last_cnt;

    // ----------------------------------------------------------------
    // ratio decode and divider
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        case (psc.ratio)
            SRT_PSC_DIV1: last_cnt = SRT_LAST_DIV1;
            SRT_PSC_DIV8: last_cnt = SRT_LAST_DIV8;
            SRT_PSC_DIV64: last_cnt = SRT_LAST_DIV64;
            SRT_PSC_DIV256: last_cnt = SRT_LAST_DIV256;
            default: last_cnt = SRT_LAST_DIV1;
        endcase
        if (psc.clear)
        begin
            nxt_st.div_cnt = '0;
        end
        else if (psc.tick_in)
        begin
            if (st_ff.div_cnt >= last_cnt)
            begin
                nxt_st.div_cnt = '0;
                nxt_st.tick = 1'b1;
            end
            else
            begin
                nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign psc.tick_out = st_ff.tick;
endmodule

// ===== core/srt_timer.sv
// Local design decisions: the Wishbone slave port and the register addresses.
module srt_timer
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [srt_pkg::SRT_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [srt_pkg::SRT_DAT_W-1:0] wb_dat_i,
    output logic [srt_pkg::SRT_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // timer inputs
    input wire logic external_count_clock_pin_i,
    input wire logic lp_osc_i,
    input wire logic gate_i,
    input wire logic chip_idle_i,
    // timer outputs
    output logic [srt_pkg::SRT_CNT_W-1:0] count_o,
    output logic timer_event_o,
    output logic irq_o
);
    import srt_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic count_run_enable;
        logic halt_in_idle;
        logic gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic ext_clock_sync_select;
        logic clock_source_select;
        logic lp_osc_select;
        logic [SRT_CNT_W-1:0] count;
        logic [SRT_CNT_W-1:0] period;
        logic evt_status;
        logic evt_mask;
        logic ext_prev;
        logic [1:0] resync;
        logic evt_pulse;
        logic ack;
        logic [SRT_DAT_W-1:0] rdata;
    } srt_state_s;

    srt_state_s st_ff;
    srt_state_s nxt_st;

    srt_psc_if psc_link ();

    srt_mode_e mode;
    logic running;
    logic ext_level;
    logic ext_rise;
    logic src_tick;
    logic cnt_tick;
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic sel_lo;
    logic sel_hi;
    logic hit_ctrl;
    logic hit_count;
    logic hit_period;
    logic hit_status;
    logic hit_mask;
    logic hit_cfg;
    logic [15:0] ctrl_view;
    logic [SRT_DAT_W-1:0] rd_mux;

    // ----------------------------------------------------------------
    // byte-lane merge for 16-bit registers
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16
    (
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic lo_en,
        input logic hi_en
    );
        logic [15:0] res;
        res = old_val;
        if (lo_en)
        begin
            res[7:0] = new_val[7:0];
        end
        if (hi_en)
        begin
            res[15:8] = new_val[15:8];
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // internal source ignores sync, external source ignores gate
    always_comb
    begin
        if (!st_ff.clock_source_select)
        begin
            mode = st_ff.gate_accumulate_enable ? SRT_MODE_GATED
                                                : SRT_MODE_TIMER;
        end
        else
        begin
            mode = st_ff.ext_clock_sync_select ? SRT_MODE_SYNC_CNT
                                               : SRT_MODE_ASYNC_CNT;
        end
    end

    // run unless stopped or idle-halted
    assign running = st_ff.count_run_enable
                     && !(st_ff.halt_in_idle && chip_idle_i);

    // external path: pin or low-power oscillator, rising edges only
    assign ext_level = st_ff.lp_osc_select ? lp_osc_i
                                           : external_count_clock_pin_i;
    assign ext_rise = ext_level && !st_ff.ext_prev;

    // ----------------------------------------------------------------
    // clock source selection
    // ----------------------------------------------------------------
    always_comb
    begin
        case (mode)
            SRT_MODE_TIMER: src_tick = 1'b1;
            SRT_MODE_GATED: src_tick = gate_i;
            SRT_MODE_SYNC_CNT: src_tick = ext_rise;
            SRT_MODE_ASYNC_CNT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // prescaler link
    assign psc_link.tick_in = src_tick && running;
    assign psc_link.ratio = st_ff.prescale_select;
    assign psc_link.clear = wr_acc && (hit_ctrl || hit_count);

    srt_prescaler u_prescaler
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .psc(psc_link)
    );

    // sync mode takes the resynchronised prescaler output, async does not
    assign cnt_tick = running
                      && ((mode == SRT_MODE_SYNC_CNT) ? st_ff.resync[1]
                                                      : psc_link.tick_out);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign access = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr_acc = access && wb_we_i;
    assign rd_acc = access && !wb_we_i;
    assign sel_lo = wb_sel_i[0];
    assign sel_hi = wb_sel_i[1];
    assign hit_ctrl = (wb_adr_i == SRT_OFS_CTRL);
    assign hit_count = (wb_adr_i == SRT_OFS_COUNT);
    assign hit_period = (wb_adr_i == SRT_OFS_PERIOD);
    assign hit_status = (wb_adr_i == SRT_OFS_STATUS);
    assign hit_mask = (wb_adr_i == SRT_OFS_MASK);
    assign hit_cfg = (wb_adr_i == SRT_OFS_CFG);

    // control view, unimplemented bits tied low
    always_comb
    begin
        ctrl_view = 16'h0000;
        ctrl_view[SRT_BIT_RUN] = st_ff.count_run_enable;
        ctrl_view[SRT_BIT_IDLE_HALT] = st_ff.halt_in_idle;
        ctrl_view[SRT_BIT_GATE] = st_ff.gate_accumulate_enable;
        ctrl_view[SRT_BIT_PSC_HI:SRT_BIT_PSC_LO] = st_ff.prescale_select;
        ctrl_view[SRT_BIT_SYNC] = st_ff.ext_clock_sync_select;
        ctrl_view[SRT_BIT_SRC] = st_ff.clock_source_select;
    end

    // read multiplexer, unmapped reads zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux[15:0] = ctrl_view;
        end
        else if (hit_count)
        begin
            rd_mux[15:0] = st_ff.count;
        end
        else if (hit_period)
        begin
            rd_mux[15:0] = st_ff.period;
        end
        else if (hit_status)
        begin
            rd_mux[SRT_BIT_EVT] = st_ff.evt_status;
        end
        else if (hit_mask)
        begin
            rd_mux[SRT_BIT_EVT] = st_ff.evt_mask;
        end
        else if (hit_cfg)
        begin
            rd_mux[SRT_BIT_LPOSC] = st_ff.lp_osc_select;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ext_prev = ext_level;
        nxt_st.resync[0] = psc_link.tick_out;
        nxt_st.resync[1] = st_ff.resync[0];
        nxt_st.evt_pulse = 1'b0;
        nxt_st.ack = access;
        if (access)
        begin
            nxt_st.rdata = rd_mux;
        end

        // count advance and period match
        if (cnt_tick)
        begin
            if (st_ff.count == st_ff.period)
            begin
                nxt_st.count = '0;
                nxt_st.evt_pulse = 1'b1;
            end
            else
            begin
                nxt_st.count = st_ff.count + 16'h0001;
            end
        end

        // register writes; software write to count wins over a tick
        if (wr_acc && hit_ctrl)
        begin
            if (sel_hi)
            begin
                nxt_st.count_run_enable = wb_dat_i[SRT_BIT_RUN];
                nxt_st.halt_in_idle = wb_dat_i[SRT_BIT_IDLE_HALT];
            end
            if (sel_lo)
            begin
                nxt_st.gate_accumulate_enable = wb_dat_i[SRT_BIT_GATE];
                nxt_st.prescale_select =
                    wb_dat_i[SRT_BIT_PSC_HI:SRT_BIT_PSC_LO];
                nxt_st.ext_clock_sync_select = wb_dat_i[SRT_BIT_SYNC];
                nxt_st.clock_source_select = wb_dat_i[SRT_BIT_SRC];
            end
        end
        if (wr_acc && hit_count)
        begin
            nxt_st.count = merge16(st_ff.count, wb_dat_i[15:0],
                                   sel_lo, sel_hi);
        end
        if (wr_acc && hit_period)
        begin
            nxt_st.period = merge16(st_ff.period, wb_dat_i[15:0],
                                    sel_lo, sel_hi);
        end
        if (wr_acc && hit_mask && sel_lo)
        begin
            nxt_st.evt_mask = wb_dat_i[SRT_BIT_EVT];
        end
        if (wr_acc && hit_cfg && sel_lo)
        begin
            nxt_st.lp_osc_select = wb_dat_i[SRT_BIT_LPOSC];
        end

        // sticky status: read clears, a new event wins
        if (rd_acc && hit_status)
        begin
            nxt_st.evt_status = 1'b0;
        end
        if (nxt_st.evt_pulse)
        begin
            nxt_st.evt_status = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
            st_ff.count <= SRT_COUNT_RST;
            st_ff.period <= SRT_PERIOD_RST;
            st_ff.count_run_enable <= SRT_CTRL_RST[SRT_BIT_RUN];
            st_ff.prescale_select <=
                SRT_CTRL_RST[SRT_BIT_PSC_HI:SRT_BIT_PSC_LO];
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    assign count_o = st_ff.count;
    assign timer_event_o = st_ff.evt_pulse;
    assign irq_o = st_ff.evt_status && st_ff.evt_mask;
endmodule

// ===== tb/srt_ext_src.sv
module srt_ext_src
(
    // clock
    input wire logic clk_i,
    // control
    input wire logic en_i,
    input wire logic [3:0] half_i,
    // output
    output logic clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff;

    // square wave, parked low between bursts
    always_ff @(posedge clk_i)
    begin
        if (!en_i)
        begin
            cnt_ff <= 4'h0;
            clk_o <= 1'b0;
        end
        else if (cnt_ff == half_i - 4'h1)
        begin
            cnt_ff <= 4'h0;
            clk_o <= !clk_o;
        end
        else
            cnt_ff <= cnt_ff + 4'h1;
    end
endmodule

// ===== tb/srt_timer_chk.sv
module srt_timer_chk
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [srt_pkg::SRT_ADR_W-1:0] wb_adr_i,
    input wire logic [srt_pkg::SRT_DAT_W-1:0] wb_dat_i,
    input wire logic [srt_pkg::SRT_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // timer
    input wire logic gate_i,
    input wire logic chip_idle_i,
    input wire logic [srt_pkg::SRT_CNT_W-1:0] count_o,
    input wire logic timer_event_o,
    input wire logic irq_o
);
    import srt_pkg::*;
    // ----------------------------------------------------------------
    // shadow state
    // ----------------------------------------------------------------
    logic [15:0] ctl_ff;
    logic msk_ff;
    logic [15:0] cnt_ff;
    logic [8:0] gap_ff;
    logic [2:0] fz_ff;
    logic wr;
    logic chg;
    logic frz;
    logic [7:0] last;

    // write strobe, count change, frozen, prescale step
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign chg = count_o != cnt_ff;
    assign frz = !ctl_ff[SRT_BIT_RUN]
        || (ctl_ff[SRT_BIT_IDLE_HALT] && chip_idle_i);
    assign last = (ctl_ff[5:4] == SRT_PSC_DIV8) ? SRT_LAST_DIV8
        : (ctl_ff[5:4] == SRT_PSC_DIV64) ? SRT_LAST_DIV64
        : (ctl_ff[5:4] == SRT_PSC_DIV256) ? SRT_LAST_DIV256
        : SRT_LAST_DIV1;

    // control and mask shadows, gap and freeze counters
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctl_ff <= 16'h0000;
            msk_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            gap_ff <= 9'h000;
            fz_ff <= 3'h0;
        end
        else
        begin
            cnt_ff <= count_o;
            gap_ff <= chg ? 9'h000 : gap_ff + {8'h00, gap_ff != 9'h1ff};
            fz_ff <= (wr || !frz) ? 3'h0 : fz_ff + {2'h0, fz_ff != 3'h7};
            if (wr && wb_adr_i == SRT_OFS_CTRL)
                ctl_ff <= wb_dat_i[15:0];
            if (wr && wb_adr_i == SRT_OFS_MASK)
                msk_ff <= wb_dat_i[0];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    property p_rsv;
        wb_ack_o && !wb_we_i && wb_adr_i == SRT_OFS_CTRL
            |-> (wb_dat_o & 32'hffff_5f89) == 32'h0000_0000;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");

    property p_step;
        chg && !$past(wr) |-> count_o == cnt_ff + 16'h0001
            || count_o == 16'h0000;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");

    property p_psc;
        chg && !$past(wr) |-> gap_ff >= {1'b0, last};
    endproperty
    a_psc: assert property (p_psc) else $error("tick too early");

    property p_frz;
        fz_ff >= 3'h4 |-> !chg;
    endproperty
    a_frz: assert property (p_frz) else $error("count moved");

    property p_gate;
        (ctl_ff[SRT_BIT_GATE] && !ctl_ff[SRT_BIT_SRC] && !gate_i && !wr)
            [*4] |=> !chg;
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");

    property p_evt;
        timer_event_o |-> count_o == 16'h0000;
    endproperty
    a_evt: assert property (p_evt) else $error("event count");

    property p_irq;
        timer_event_o && msk_ff |-> ##[0:1] irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
endmodule

bind srt_timer srt_timer_chk chk_u
(
    .clk_i,
    .rst_i,
    .wb_cyc_i,
    .wb_stb_i,
    .wb_we_i,
    .wb_adr_i,
    .wb_dat_i,
    .wb_dat_o,
    .wb_ack_o,
    .gate_i,
    .chip_idle_i,
    .count_o,
    .timer_event_o,
    .irq_o
);

// ===== tb/srt_timer_tb_top.sv
module srt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import srt_pkg::*;
    // f: bit2 low-power source, bit1 gate level, bit0 idle level
    typedef struct {logic [15:0] c; logic [2:0] f;} srt_case_s;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic gate_i = 1'b0;
    logic chip_idle_i = 1'b0;
    logic en_pin = 1'b0;
    logic en_lpo = 1'b0;
    logic [3:0] half = 4'h2;
    logic [31:0] wb_dat_o, rd, d;
    logic wb_ack_o, timer_event_o, irq_o;
    logic external_count_clock_pin_i, lp_osc_i;
    logic [15:0] count_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int n, p;
    srt_case_s tc[15] = '{
        '{16'h8000, 3'h0}, '{16'h8010, 3'h0},
        '{16'h8020, 3'h0}, '{16'h8030, 3'h0},
        '{16'h8004, 3'h0}, '{16'h8002, 3'h0},
        '{16'h8006, 3'h0}, '{16'h8016, 3'h0},
        '{16'h8042, 3'h0}, '{16'h8002, 3'h4},
        '{16'h8040, 3'h2}, '{16'h8040, 3'h0},
        '{16'ha000, 3'h1}, '{16'h8000, 3'h1},
        '{16'h0000, 3'h0}};

    srt_timer dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .external_count_clock_pin_i, .lp_osc_i, .gate_i, .chip_idle_i,
        .count_o, .timer_event_o, .irq_o);
    srt_ext_src pin_u (.clk_i, .en_i(en_pin), .half_i(half),
        .clk_o(external_count_clock_pin_i));
    srt_ext_src lpo_u (.clk_i, .en_i(en_lpo), .half_i(half),
        .clk_o(lp_osc_i));

    // 200 MHz system clock
    always #2.5 clk_i = !clk_i;

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input int v);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= v;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // edges passed until the next event, limit counts as a mismatch
    task automatic wait_evt(output int k);
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (timer_event_o !== 1'b1 && k < 300);
        n_mismatch += (k >= 300);
    endtask

    // cycles between two count steps, 0 when frozen
    function automatic int exp_gap(logic [15:0] c, logic [2:0] f, int h);
        int r;
        r = (c[5:4] == 2'h3) ? 256 : 1 << (3 * c[5:4]);
        if (!c[15] || (c[13] && f[0]) || (!c[1] && c[6] && !f[1]))
            return 0;
        return c[1] ? r * 2 * h : r;
    endfunction

    task automatic run_case(input srt_case_s t);
        int h, g;
        logic [15:0] v;
        h = 2 + ($urandom % 4);
        wb(1'b1, SRT_OFS_CTRL, 0);
        wb(1'b1, SRT_OFS_COUNT, 0);
        wb(1'b1, SRT_OFS_CFG, int'(t.f[2]));
        half <= 4'(h);
        en_pin <= !t.f[2];
        en_lpo <= t.f[2];
        gate_i <= t.f[1];
        chip_idle_i <= t.f[0];
        wb(1'b1, SRT_OFS_CTRL, int'(t.c));
        g = 0;
        v = count_o;
        do @(posedge clk_i); while (count_o === v && ++g < 600);
        v = count_o;
        g = 0;
        do @(posedge clk_i); while (count_o === v && ++g < 600);
        if (g == 600)
            g = 0;
        else
            g++;
        chk("gap", g, exp_gap(t.c, t.f, h));
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        void'($urandom(61));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, SRT_OFS_CTRL, 0);
        chk("ctrl", rd, 32'h0);
        wb(1'b0, SRT_OFS_PERIOD, 0);
        chk("period", rd, {16'h0, SRT_PERIOD_RST});
        wb(1'b1, 8'h20, $urandom);
        wb(1'b0, 8'h20, 0);
        chk("unmapped", rd, 32'h0);
        repeat (4)
        begin
            d = $urandom & 32'hffff_7fff;
            wb(1'b1, SRT_OFS_CTRL, d);
            wb(1'b0, SRT_OFS_CTRL, 0);
            chk("ctrl_rb", rd, d & 32'h2076);
        end
        foreach (tc[i])
            run_case(tc[i]);
        en_pin <= 1'b0;
        en_lpo <= 1'b0;
        gate_i <= 1'b0;
        chip_idle_i <= 1'b0;
        p = 3 + ($urandom % 6);
        wb(1'b1, SRT_OFS_CTRL, 0);
        wb(1'b1, SRT_OFS_CFG, 0);
        wb(1'b1, SRT_OFS_COUNT, 0);
        wb(1'b1, SRT_OFS_PERIOD, p);
        wb(1'b1, SRT_OFS_MASK, 1);
        wb(1'b1, SRT_OFS_CTRL, 32'h8000);
        wait_evt(n);
        wait_evt(n);
        chk("evt_gap", n, p + 1);
        chk("evt_cnt", {16'h0, count_o}, 32'h0);
        @(posedge clk_i);
        chk("irq_on", {31'h0, irq_o}, 32'h1);
        wb(1'b1, SRT_OFS_CTRL, 0);
        wb(1'b0, SRT_OFS_STATUS, 0);
        chk("status", rd, 32'h1);
        wb(1'b0, SRT_OFS_STATUS, 0);
        chk("status_clr", rd, 32'h0);
        chk("irq_off", {31'h0, irq_o}, 32'h0);
        wb(1'b1, SRT_OFS_MASK, 0);
        wb(1'b1, SRT_OFS_CTRL, 32'h8000);
        wait_evt(n);
        @(posedge clk_i);
        chk("irq_mask", {31'h0, irq_o}, 32'h0);
        wb(1'b1, SRT_OFS_CTRL, 0);
        summarize;
    end

    // watchdog, far beyond the expected run
    initial
    begin
        #200us;
        n_mismatch++;
        summarize;
    end
endmodule
